//--- hw/pim_irq_top.sv
// interrupt manager of a 10/100 transceiver with its management port
`timescale 1ns/100ps
`default_nettype none

module pim_irq_top
  import pim_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS // shorten in simulation
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] phyAddr,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic energyDetect,
  input wire logic anComplete,
  input wire logic remoteFault,
  input wire logic linkStatus,
  input wire logic lpAck,
  input wire logic parDetFault,
  input wire logic pageReceived,
  input wire logic renegotiate,
  output logic irqNOut
);

  pim_smi_if smiBus();

  // serial framing lives in its own module
  pim_smi_engine pim_smi_engine_i (
    .mclk(mclk),
    .reset(reset),
    .phyAddr(phyAddr),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .bus(smiBus.engine)
  );

  logic [15:0] mask_q; // interrupt mask register
  logic [7:0] flags_q; // source flags, bit 0 unused
  logic altMode_q; // alternate mode select
  logic maskWritten_q; // host has written the mask
  logic acqActive_q; // signal acquisition still running
  logic energyEff; // energy level seen by software
  logic [7:0] active; // per-source active level
  logic [7:0] activePrev_q; // last cycle's active levels
  logic [7:0] rise; // source became active
  logic [7:0] fall; // source became inactive
  logic [7:0] relPri; // primary-mode release events
  logic [7:0] clr; // flag clear request this cycle
  logic rd1;
  logic rd6;
  logic rd29;
  logic wr29;
  logic wr30;
  logic wr17;
  logic linkDownEv;
  logic energyRelease; // flag 7 released while energy high
  logic irqReq; // combined request before the output flop
  logic msTick; // one-cycle pulse each millisecond
  logic [$clog2(CYC_PER_MS_P)-1:0] divCnt_q;
  logic [MS_CNT_W-1:0] msCnt_q; // energy pulse timer
  logic [MS_CNT_W-1:0] acqCnt_q; // acquisition timer
  pim_energy_state_type enState_q;
  logic [15:0] rdMux;

  // decode of register accesses from the serial engine
  assign rd1 = smiBus.rdStrobe & (smiBus.regAddr == REG_BASIC_STATUS);
  assign rd6 = smiBus.rdStrobe & (smiBus.regAddr == REG_AN_EXPANSION);
  assign rd29 = smiBus.rdStrobe &
                (smiBus.regAddr == REG_IRQ_SOURCE_FLAGS);
  assign wr29 = smiBus.wrStrobe &
                (smiBus.regAddr == REG_IRQ_SOURCE_FLAGS);
  assign wr30 = smiBus.wrStrobe & (smiBus.regAddr == REG_IRQ_MASK);
  assign wr17 = smiBus.wrStrobe & (smiBus.regAddr == REG_MODE_CTRL);

  // millisecond enable shared by every slow timer
  always_ff @(posedge mclk) begin
    if (reset) begin
      divCnt_q <= '0;
    end else if (divCnt_q == ($bits(divCnt_q))'(CYC_PER_MS_P - 1)) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end

  assign msTick = (divCnt_q == ($bits(divCnt_q))'(CYC_PER_MS_P - 1));

  // energy reads one during acquisition even before the line shows it
  always_ff @(posedge mclk) begin
    if (reset) begin
      acqActive_q <= 1'h1;
      acqCnt_q <= '0;
    end else if (acqActive_q && msTick) begin
      acqCnt_q <= acqCnt_q + 1'b1;
      if (acqCnt_q == MS_CNT_W'(ACQ_WINDOW_MS - 1)) begin
        acqActive_q <= 1'h0;
      end
    end
  end

  assign energyEff = energyDetect | acqActive_q;

  // active levels: link down is active when link status is low
  always_comb begin
    active = 8'h00;
    active[SRC_ENERGY] = energyEff;
    active[SRC_AN_DONE] = anComplete;
    active[SRC_RFAULT] = remoteFault;
    active[SRC_LINK_DOWN] = ~linkStatus;
    active[SRC_LP_ACK] = lpAck;
    active[SRC_PD_FAULT] = parDetFault;
    active[SRC_PAGE_RX] = pageReceived;
  end

  // edge history; energy starts high so acquisition raises no event
  always_ff @(posedge mclk) begin
    if (reset) begin
      activePrev_q <= 8'h80;
    end else begin
      activePrev_q <= active;
    end
  end

  assign rise = active & ~activePrev_q;
  assign fall = ~active & activePrev_q;
  assign linkDownEv = rise[SRC_LINK_DOWN];

  // primary-mode release events per source
  always_comb begin
    relPri = fall & FALL_REL;
    if (rd29) begin
      relPri = relPri | 8'hfe;
    end
    if (rd1) begin
      relPri = relPri | RD1_REL;
    end
    if (rd6 || renegotiate || linkDownEv) begin
      relPri = relPri | RD6_REL;
    end
  end

  // per-source flag: mode picks the clear condition, set wins
  genvar gi;
  generate
    for (gi = 1; gi < 8; gi++) begin : gSrc
      // alternate mode only clears once the source is inactive
      assign clr[gi] = altMode_q ?
        (wr29 & smiBus.wrData[gi] & ~active[gi]) :
        relPri[gi];

      always_ff @(posedge mclk) begin
        if (reset) begin
          flags_q[gi] <= FLAGS_RESET[gi];
        end else if (rise[gi]) begin
          flags_q[gi] <= 1'h1;
        end else if (clr[gi]) begin
          flags_q[gi] <= 1'h0;
        end
      end
    end
  endgenerate

  assign clr[0] = 1'h0;
  assign flags_q[0] = 1'h0;

  // mask register; the energy bit follows the end of acquisition
  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_q <= MASK_RESET;
      maskWritten_q <= 1'h0;
    end else if (wr30) begin
      mask_q <= smiBus.wrData;
      maskWritten_q <= 1'h1;
    end else if (acqActive_q && msTick && !energyDetect &&
                 !maskWritten_q &&
                 acqCnt_q == MS_CNT_W'(ACQ_WINDOW_MS - 1)) begin
      mask_q[SRC_ENERGY] <= 1'h0;
    end
  end

  // mode select; only the host sets alternate mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      altMode_q <= ALT_MODE_RESET;
    end else if (wr17) begin
      altMode_q <= smiBus.wrData[BIT_ALT_MODE];
    end
  end

  // a primary release of energy while still high arms the late pulse
  assign energyRelease = ~altMode_q & flags_q[SRC_ENERGY] &
                         clr[SRC_ENERGY] & ~rise[SRC_ENERGY] &
                         energyEff & mask_q[SRC_ENERGY];

  // late energy pulse: about a second after energy drops, for 256 ms
  // clearing the energy mask cancels it at any point
  always_ff @(posedge mclk) begin
    if (reset) begin
      enState_q <= EN_IDLE;
      msCnt_q <= '0;
    end else if (!mask_q[SRC_ENERGY]) begin
      enState_q <= EN_IDLE;
      msCnt_q <= '0;
    end else begin
      case (enState_q)
        EN_IDLE: begin
          if (energyRelease) begin
            enState_q <= EN_ARMED;
          end
        end
        EN_ARMED: begin
          if (fall[SRC_ENERGY]) begin
            enState_q <= EN_WAIT;
            msCnt_q <= '0;
          end
        end
        EN_WAIT: begin
          // fresh energy starts a normal flag event instead
          if (rise[SRC_ENERGY]) begin
            enState_q <= EN_IDLE;
          end else if (msTick) begin
            msCnt_q <= msCnt_q + 1'b1;
            if (msCnt_q == MS_CNT_W'(REASSERT_DELAY_MS - 1)) begin
              enState_q <= EN_PULSE;
              msCnt_q <= '0;
            end
          end
        end
        EN_PULSE: begin
          if (msTick) begin
            msCnt_q <= msCnt_q + 1'b1;
            if (msCnt_q == MS_CNT_W'(REASSERT_PULSE_MS - 1)) begin
              enState_q <= EN_IDLE;
              msCnt_q <= '0;
            end
          end
        end
        default: begin
          enState_q <= EN_IDLE;
          msCnt_q <= '0;
        end
      endcase
    end
  end

  // any unmasked flag, or the late energy pulse, pulls irq low
  assign irqReq = |(flags_q & mask_q[7:0]) |
                  ((enState_q == EN_PULSE) & mask_q[SRC_ENERGY]);

  // registered output keeps glitches off the pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqNOut <= 1'h1;
    end else begin
      irqNOut <= ~irqReq;
    end
  end

  // read value of the addressed register
  always_comb begin
    rdMux = 16'h0000;
    case (smiBus.regAddr)
      REG_BASIC_STATUS: begin
        rdMux[BIT_AN_COMPLETE] = anComplete;
        rdMux[BIT_REMOTE_FAULT] = remoteFault;
        rdMux[BIT_LINK_STATUS] = linkStatus;
      end
      REG_LP_ABILITY: begin
        rdMux[BIT_LP_ACK] = lpAck;
      end
      REG_AN_EXPANSION: begin
        rdMux[BIT_PAR_DET_FAULT] = parDetFault;
        rdMux[BIT_PAGE_RX] = pageReceived;
      end
      REG_MODE_CTRL: begin
        rdMux[BIT_ENERGY] = energyEff;
        rdMux[BIT_ALT_MODE] = altMode_q;
      end
      REG_IRQ_SOURCE_FLAGS: begin
        rdMux = {8'h00, flags_q};
      end
      REG_IRQ_MASK: begin
        rdMux = mask_q;
      end
      default: begin
        // unimplemented standard registers 0x07 to 0x0f read all ones
        if (smiBus.regAddr >= REG_UNSUP_LO &&
            smiBus.regAddr <= REG_UNSUP_HI) begin
          rdMux = UNSUP_READ;
        end
      end
    endcase
  end

  assign smiBus.rdData = rdMux;

endmodule : pim_irq_top
`default_nettype wire

//--- hw/pim_pkg.sv
// shared constants and types of the phy interrupt manager
package pim_pkg;

  // management register addresses
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_LP_ABILITY = 5'h05;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_MODE_CTRL = 5'h11;
  localparam logic [4:0] REG_IRQ_SOURCE_FLAGS = 5'h1d;
  localparam logic [4:0] REG_IRQ_MASK = 5'h1e;
  localparam logic [4:0] REG_UNSUP_LO = 5'h07;
  localparam logic [4:0] REG_UNSUP_HI = 5'h0f;

  // status bit positions inside the status registers
  localparam int BIT_AN_COMPLETE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_LINK_STATUS = 2;
  localparam int BIT_LP_ACK = 14;
  localparam int BIT_PAR_DET_FAULT = 4;
  localparam int BIT_PAGE_RX = 1;
  localparam int BIT_ENERGY = 1;
  localparam int BIT_ALT_MODE = 6;

  // interrupt source index = bit in flag and mask registers
  localparam int SRC_ENERGY = 7;
  localparam int SRC_AN_DONE = 6;
  localparam int SRC_RFAULT = 5;
  localparam int SRC_LINK_DOWN = 4;
  localparam int SRC_LP_ACK = 3;
  localparam int SRC_PD_FAULT = 2;
  localparam int SRC_PAGE_RX = 1;

  // which sources each primary-mode release event reaches
  localparam logic [7:0] FALL_REL = 8'hee;
  localparam logic [7:0] RD1_REL = 8'h30;
  localparam logic [7:0] RD6_REL = 8'h06;

  // reset values
  localparam logic [15:0] MASK_RESET = 16'h0080;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic ALT_MODE_RESET = 1'h0;
  localparam logic [15:0] UNSUP_READ = 16'hffff;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int REASSERT_PULSE_MS = 256;
  localparam int REASSERT_DELAY_MS = 1000;
  localparam int ACQ_WINDOW_MS = 4;
  localparam int MS_CNT_W = 11;

  // serial management framing
  localparam int PREAMBLE_LEN = 32;
  localparam int HDR_LAST = 12;
  localparam int DATA_BITS = 16;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [5:0] {
    SMI_PRE = 6'h01,
    SMI_HDR = 6'h02,
    SMI_RTA = 6'h04,
    SMI_RDATA = 6'h08,
    SMI_WTA = 6'h10,
    SMI_WDATA = 6'h20
  } pim_smi_state_type;

  typedef enum logic [3:0] {
    EN_IDLE = 4'h1,
    EN_ARMED = 4'h2,
    EN_WAIT = 4'h4,
    EN_PULSE = 4'h8
  } pim_energy_state_type;

endpackage : pim_pkg

//--- hw/pim_smi_engine.sv
// serial management frame engine sampling mdc/mdio on mclk
`timescale 1ns/100ps
`default_nettype none
module pim_smi_engine
  import pim_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] phyAddr,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  pim_smi_if.engine bus
);

  logic [2:0] mdcSync_q; // three-stage synchroniser for mdc
  logic [2:0] mdioSync_q; // three-stage synchroniser for mdio
  logic mdcLvl_q; // accepted mdc level
  logic mdcRise; // one-cycle enable on accepted mdc rise
  logic bitIn; // settled mdio bit
  pim_smi_state_type state_q;
  logic [5:0] cnt_q; // preamble or bit counter
  logic [11:0] hdr_q; // collected header bits
  logic [12:0] hdrFull; // header including current bit
  logic [15:0] shift_q; // read or write data shifter
  logic [4:0] regAddr_q;
  logic rdStrobe_q;
  logic wrStrobe_q;

  // pins come from the management host domain
  always_ff @(posedge mclk) begin
    if (reset) begin
      mdcSync_q <= 3'h0;
      mdioSync_q <= 3'h0;
    end else begin
      mdcSync_q <= {mdcSync_q[1:0], mdc};
      mdioSync_q <= {mdioSync_q[1:0], mdioIn};
    end
  end

  // a level is accepted only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      mdcLvl_q <= 1'h0;
    end else if (mdcSync_q[1] == mdcSync_q[2]) begin
      mdcLvl_q <= mdcSync_q[2];
    end
  end

  assign mdcRise = mdcSync_q[1] & mdcSync_q[2] & ~mdcLvl_q;
  assign bitIn = mdioSync_q[2];
  assign hdrFull = {hdr_q, bitIn};

  // frame sequencer, advances once per mdc rise
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= SMI_PRE;
      cnt_q <= 6'h00;
      hdr_q <= 12'h000;
      shift_q <= 16'h0000;
      regAddr_q <= 5'h00;
      rdStrobe_q <= 1'h0;
      wrStrobe_q <= 1'h0;
      mdioOut <= 1'h0;
      mdioOe <= 1'h0;
    end else begin
      rdStrobe_q <= 1'h0;
      wrStrobe_q <= 1'h0;
      // read value is caught before the read side effects land
      if (rdStrobe_q) begin
        shift_q <= bus.rdData;
      end
      if (mdcRise) begin
        case (state_q)
          SMI_PRE: begin
            if (bitIn) begin
              if (cnt_q != 6'(PREAMBLE_LEN)) begin
                cnt_q <= cnt_q + 6'h01;
              end
            end else if (cnt_q == 6'(PREAMBLE_LEN)) begin
              state_q <= SMI_HDR; // first start bit seen
              cnt_q <= 6'h00;
            end else begin
              cnt_q <= 6'h00;
            end
          end
          SMI_HDR: begin
            hdr_q <= hdrFull[11:0];
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'(HDR_LAST)) begin
              cnt_q <= 6'h00;
              regAddr_q <= hdrFull[4:0];
              // frames for other addresses fall back to preamble hunt
              if (!hdrFull[12] || hdrFull[9:5] != phyAddr) begin
                state_q <= SMI_PRE;
              end else if (hdrFull[11:10] == OP_READ) begin
                state_q <= SMI_RTA;
                rdStrobe_q <= 1'h1;
              end else if (hdrFull[11:10] == OP_WRITE) begin
                state_q <= SMI_WTA;
              end else begin
                state_q <= SMI_PRE;
              end
            end
          end
          SMI_RTA: begin
            mdioOut <= 1'h0; // second turnaround bit driven low
            mdioOe <= 1'h1;
            state_q <= SMI_RDATA;
          end
          SMI_RDATA: begin
            if (cnt_q == 6'(DATA_BITS)) begin
              mdioOe <= 1'h0;
              state_q <= SMI_PRE;
              cnt_q <= 6'h00;
            end else begin
              mdioOut <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'h0};
              cnt_q <= cnt_q + 6'h01;
            end
          end
          SMI_WTA: begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h01) begin
              state_q <= SMI_WDATA;
              cnt_q <= 6'h00;
            end
          end
          SMI_WDATA: begin
            shift_q <= {shift_q[14:0], bitIn};
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'(DATA_BITS - 1)) begin
              wrStrobe_q <= 1'h1;
              state_q <= SMI_PRE;
              cnt_q <= 6'h00;
            end
          end
          default: begin
            state_q <= SMI_PRE;
            cnt_q <= 6'h00;
          end
        endcase
      end
    end
  end

  assign bus.regAddr = regAddr_q;
  assign bus.rdStrobe = rdStrobe_q;
  assign bus.wrStrobe = wrStrobe_q;
  assign bus.wrData = shift_q;

endmodule : pim_smi_engine
`default_nettype wire

//--- hw/pim_smi_if.sv
// register access strobes between serial engine and register logic
`timescale 1ns/100ps
`default_nettype none
interface pim_smi_if;
  logic [4:0] regAddr; // register addressed by current frame
  logic rdStrobe; // one-cycle pulse, read taken
  logic [15:0] rdData; // read value, combinational from regs
  logic wrStrobe; // one-cycle pulse, write data complete
  logic [15:0] wrData; // write value, valid with wrStrobe
  modport engine(output regAddr, rdStrobe, wrStrobe, wrData,
                 input rdData);
  modport regs(input regAddr, rdStrobe, wrStrobe, wrData,
               output rdData);
endinterface : pim_smi_if
`default_nettype wire

//--- sim/phy_interrupt_manager_test.sv
// self-checking bench of the phy interrupt manager
`timescale 1ns/100ps
`default_nettype none
module phy_interrupt_manager_test;
  import pim_pkg::*;
  localparam int CPM = 4; // cycles per ms, keeps the run short
  localparam int LATE = REASSERT_DELAY_MS * CPM;
  localparam int PULSE = REASSERT_PULSE_MS * CPM;
  logic mclk, reset, renegotiate;
  logic mdc, mdioIn, mdioOut, mdioOe, irqNOut;
  logic [4:0] phy; // address strapped for this run
  logic [6:0] src; // energy, autoneg, fault, link, ack, pdf, page
  logic [15:0] rd; // last read value
  int nMismatch;
  int comparisons;
  int s; // source under test

  pim_irq_top #(.CYC_PER_MS_P(CPM)) pim_irq_top_i (
    .mclk(mclk), .reset(reset), .phyAddr(phy), .mdc(mdc),
    .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .energyDetect(src[6]), .anComplete(src[5]), .remoteFault(src[4]),
    .linkStatus(src[3]), .lpAck(src[2]), .parDetFault(src[1]),
    .pageReceived(src[0]), .renegotiate(renegotiate), .irqNOut(irqNOut));
  pim_smi_host pim_smi_host_i (.mdc(mdc), .mdioIn(mdioIn),
    .mdioOut(mdioOut), .mdioOe(mdioOe));

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // expected flag word of one source
  function automatic logic [15:0] flagOf(input int n);
    return 16'h0001 << n;
  endfunction : flagOf

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic cmpIrq(input logic exp);
    comparisons++;
    if (irqNOut !== exp) begin
      nMismatch++;
      $display("FAIL irqNOut expected %b seen %b", exp, irqNOut);
    end
  endtask : cmpIrq

  task automatic rdReg(input logic [4:0] a);
    pim_smi_host_i.frame(OP_READ, phy, a, 16'h0000, rd);
    tick(4);
  endtask : rdReg

  // write lands some cycles after the last data bit
  task automatic wrReg(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] unused;
    pim_smi_host_i.frame(OP_WRITE, phy, a, d, unused);
    tick(8);
  endtask : wrReg

  // link events are a fall, all others a rise
  task automatic drive(input int n, input logic on);
    src[n - 1] = (n == SRC_LINK_DOWN) ? !on : on;
    tick(4);
  endtask : drive

  task automatic doReset(input logic energy);
    reset = 1'b1;
    src[6] = energy;
    tick(6);
    reset = 1'b0;
    tick(1);
  endtask : doReset

  task automatic completeRun;
    $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : completeRun

  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    nMismatch++;
    completeRun();
  end

  initial begin
    reset = 1'b1;
    renegotiate = 1'b0;
    src = 7'h08;
    nMismatch = 0;
    comparisons = 0;
    void'($urandom(25));
    phy = 5'($urandom_range(31));
    // energy kept up past acquisition holds its mask bit
    doReset(1'b1);
    cmpIrq(1'b1);
    rdReg(REG_IRQ_MASK);
    cmp("mask", MASK_RESET, rd);
    rdReg(REG_MODE_CTRL);
    cmp("mode", 16'h0002, rd & 16'h0042);
    // no signal: mask bit goes once the window ends
    doReset(1'b0);
    rdReg(REG_IRQ_MASK);
    cmp("mask", 16'h0000, rd);
    rdReg(REG_UNSUP_LO);
    cmp("unsupported", UNSUP_READ, rd);
    rdReg(5'h1f);
    cmp("unmapped", 16'h0000, rd);
    pim_smi_host_i.frame(OP_READ, phy ^ 5'h01, REG_IRQ_MASK, 16'h0, rd);
    cmp("foreign address", 16'hffff, rd);
    // masked event leaves irq alone
    drive(SRC_AN_DONE, 1'b1);
    cmpIrq(1'b1);
    drive(SRC_AN_DONE, 1'b0);
    rdReg(REG_IRQ_SOURCE_FLAGS);
    // primary mode: random sources, released by fall or flag read
    wrReg(REG_IRQ_MASK, 16'h007e);
    for (int k = 0; k < 12; k++) begin
      s = 1 + $urandom_range(5);
      drive(s, 1'b1);
      cmpIrq(1'b0);
      tick($urandom_range(20, 1));
      if ($urandom_range(1) == 0 && s != SRC_LINK_DOWN) begin
        drive(s, 1'b0);
      end else begin
        rdReg(REG_IRQ_SOURCE_FLAGS);
        cmp("flags", flagOf(s), rd);
        drive(s, 1'b0);
      end
      cmpIrq(1'b1);
    end
    // partner acknowledge shows in its status register
    drive(SRC_LP_ACK, 1'b1);
    rdReg(REG_LP_ABILITY);
    cmp("partner ack", 16'h4000, rd & 16'h4000);
    drive(SRC_LP_ACK, 1'b0);
    // status read frees link down and remote fault together
    drive(SRC_RFAULT, 1'b1);
    drive(SRC_LINK_DOWN, 1'b1);
    rdReg(REG_BASIC_STATUS);
    cmp("status", 16'h0010, rd & 16'h0034);
    cmpIrq(1'b1);
    drive(SRC_RFAULT, 1'b0);
    drive(SRC_LINK_DOWN, 1'b0);
    // restart, then expansion read, free fault and page
    drive(SRC_PAGE_RX, 1'b1);
    renegotiate = 1'b1;
    tick(1);
    renegotiate = 1'b0;
    tick(4);
    cmpIrq(1'b1);
    drive(SRC_PD_FAULT, 1'b1);
    cmpIrq(1'b0);
    rdReg(REG_AN_EXPANSION);
    cmp("expansion", 16'h0012, rd & 16'h0012);
    cmpIrq(1'b1);
    drive(SRC_PAGE_RX, 1'b0);
    drive(SRC_PD_FAULT, 1'b0);
    // energy freed while high comes back after the cable goes
    wrReg(REG_IRQ_MASK, 16'h0080);
    drive(SRC_ENERGY, 1'b1);
    cmpIrq(1'b0);
    rdReg(REG_IRQ_SOURCE_FLAGS);
    cmp("flags", flagOf(SRC_ENERGY), rd);
    drive(SRC_ENERGY, 1'b0);
    tick(LATE - 24);
    cmpIrq(1'b1);
    tick(40);
    cmpIrq(1'b0);
    tick(PULSE - 40);
    cmpIrq(1'b0);
    tick(40);
    cmpIrq(1'b1);
    wrReg(REG_IRQ_MASK, 16'h0000);
    // alternate mode: flag write rechecks, mask clear frees
    wrReg(REG_MODE_CTRL, 16'h0040);
    rdReg(REG_MODE_CTRL);
    cmp("mode", 16'h0040, rd & 16'h0040);
    wrReg(REG_IRQ_MASK, 16'h007e);
    drive(SRC_AN_DONE, 1'b1);
    cmpIrq(1'b0);
    wrReg(REG_IRQ_SOURCE_FLAGS, flagOf(SRC_AN_DONE));
    rdReg(REG_IRQ_SOURCE_FLAGS);
    cmp("flags", flagOf(SRC_AN_DONE), rd);
    drive(SRC_AN_DONE, 1'b0);
    cmpIrq(1'b0);
    wrReg(REG_IRQ_SOURCE_FLAGS, flagOf(SRC_AN_DONE));
    cmpIrq(1'b1);
    rdReg(REG_IRQ_SOURCE_FLAGS);
    cmp("flags", 16'h0000, rd);
    drive(SRC_RFAULT, 1'b1);
    cmpIrq(1'b0);
    wrReg(REG_IRQ_MASK, 16'h005e);
    cmpIrq(1'b1);
    drive(SRC_RFAULT, 1'b0);
    completeRun();
  end
endmodule : phy_interrupt_manager_test
`default_nettype wire

//--- sim/pim_irq_top_properties.sv
// port checker of the interrupt manager, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module pim_irq_top_properties
  import pim_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS // same shortening as the top
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  input wire logic energyDetect,
  input wire logic anComplete,
  input wire logic remoteFault,
  input wire logic linkStatus,
  input wire logic lpAck,
  input wire logic parDetFault,
  input wire logic pageReceived,
  input wire logic renegotiate,
  input wire logic irqNOut
);
  localparam int LATE = REASSERT_DELAY_MS * CYC_PER_MS_P;
  localparam int PULSE = REASSERT_PULSE_MS * CYC_PER_MS_P;
  localparam int ACQ = ACQ_WINDOW_MS * CYC_PER_MS_P;
  logic [6:0] srcNow; // all source levels
  logic [6:0] srcQ; // source levels one cycle back
  logic [3:0] chgHist; // recent source edge or restart
  logic mdcQ; // mdc one cycle back
  logic [3:0] mdcAge; // cycles since mdc rose, saturating
  int efAge; // cycles since energy fell
  int rstAge; // cycles since reset
  logic mdcNear; // frame activity may explain a change
  logic late; // late energy pulse may start or end now
  logic acqEnd; // acquisition window may end now

  assign srcNow = {energyDetect, anComplete, remoteFault, linkStatus,
                   lpAck, parDetFault, pageReceived};
  assign mdcNear = mdcAge < 4'hc;
  assign late = (efAge > LATE - 8 && efAge < LATE + 8) ||
                (efAge > LATE + PULSE - 8 && efAge < LATE + PULSE + 8);
  assign acqEnd = rstAge > ACQ - 4 && rstAge < ACQ + 8;

  // a source edge may move irq only a few cycles later
  always_ff @(posedge mclk) begin
    srcQ <= srcNow;
    chgHist <= {chgHist[2:0], (srcNow != srcQ) || renegotiate};
  end

  // frames act a few cycles behind the sampled mdc rise
  always_ff @(posedge mclk) begin
    mdcQ <= mdc;
    if (reset) begin
      mdcAge <= 4'hf;
    end else if (mdc && !mdcQ) begin
      mdcAge <= 4'h0;
    end else if (mdcAge != 4'hf) begin
      mdcAge <= mdcAge + 4'h1;
    end
  end

  // long ages saturate so a quiet run never wraps them
  always_ff @(posedge mclk) begin
    if (reset) begin
      efAge <= 2 * LATE;
    end else if (srcQ[6] && !energyDetect) begin
      efAge <= 0;
    end else if (efAge < 2 * LATE) begin
      efAge <= efAge + 1;
    end
  end

  // age since reset, for the end of acquisition
  always_ff @(posedge mclk) begin
    if (reset) begin
      rstAge <= 0;
    end else if (rstAge < 2 * LATE) begin
      rstAge <= rstAge + 1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  chk_irq_idle_reset: assert property ($fell(reset) |-> irqNOut)
    else $error("irq low right after reset");
  chk_mdio_idle_reset: assert property ($fell(reset) |-> !mdioOe)
    else $error("mdio driven right after reset");
  chk_irq_fall_cause: assert property (
    $fell(irqNOut) |-> chgHist != 4'h0 || mdcNear || late)
    else $error("irq fell with no event behind it");
  chk_irq_rise_cause: assert property (
    $rose(irqNOut) |-> chgHist != 4'h0 || mdcNear || late || acqEnd)
    else $error("irq released with no release event");
  chk_late_pulse_hold: assert property (
    $fell(irqNOut) && late && chgHist == 4'h0 && !mdcNear
      |=> !irqNOut [*8])
    else $error("late energy pulse too short");
  chk_ta_drives_zero: assert property ($rose(mdioOe) |-> !mdioOut)
    else $error("turnaround not driven low");
  chk_oe_stays_up: assert property ($rose(mdioOe) |=> mdioOe [*8])
    else $error("read data dropped early");
  chk_oe_tracks_mdc: assert property ($changed(mdioOe) |-> mdcNear)
    else $error("mdio enable moved without mdc");
  chk_out_tracks_mdc: assert property ($changed(mdioOut) |-> mdcNear)
    else $error("mdio data moved without mdc");

  cover property ($fell(irqNOut) && late && !mdcNear);
  cover property ($rose(mdioOe));
  cover property ($rose(irqNOut) && mdcNear);
endmodule : pim_irq_top_properties

bind pim_irq_top pim_irq_top_properties #(
  .CYC_PER_MS_P(CYC_PER_MS_P)
) pim_irq_top_properties_i (.*);
`default_nettype wire

//--- sim/pim_smi_host.sv
// management controller model: drives mdc and its side of mdio
`timescale 1ns/100ps
`default_nettype none
module pim_smi_host
  import pim_pkg::*;
(
  output logic mdc,
  output logic mdioIn,
  input wire logic mdioOut,
  input wire logic mdioOe
);
  logic hostBit; // value the host puts on mdio
  logic hostOe; // host drives mdio

  // wire level: device, else host, else the pull-up
  assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

  // mdc stands low between frames
  initial begin
    mdc = 1'b0;
    hostBit = 1'b1;
    hostOe = 1'b0;
  end

  // one whole frame, 200 ns per bit, data sampled at each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] regA, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, op, phy, regA, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      hostOe = (op == OP_WRITE) || (i > 17); // read frees the bus at ta
      hostBit = bits[i];
      #100;
      rd = {rd[14:0], mdioIn};
      mdc = 1'b1;
      #100;
      mdc = 1'b0;
    end
    hostOe = 1'b0;
  endtask : frame
endmodule : pim_smi_host
`default_nettype wire
